// >>> pkg/ast_pkg.sv
// constants shared by the serial transceiver core and its rate generator
package ast_pkg;

  // oversample ticks per bit and the tick positions of the three votes
  localparam int unsigned OVERSAMPLE    = 16;
  localparam logic [3:0]  SAMPLE_FIRST  = 4'h7;
  localparam logic [3:0]  SAMPLE_SECOND = 4'h8;
  localparam logic [3:0]  SAMPLE_THIRD  = 4'h9;
  localparam logic [3:0]  LAST_TICK     = 4'hf;

  // fixed rates: code 000 gives 76800 baud on a 16 MHz clock, each code halves it
  localparam int unsigned REF_CLK_HZ    = 16000000;
  localparam int unsigned REF_TOP_BAUD  = 76800;
  // core cycles per oversample tick at code 000 (truncated, so rates scale with clock)
  localparam int unsigned BASE_TICK_DIV = REF_CLK_HZ / (REF_TOP_BAUD * OVERSAMPLE);
  localparam int unsigned DIV_W         = 9;
  localparam logic [2:0]  LAST_FIXED    = 3'h5;
  localparam logic [2:0]  RATE_TIMER    = 3'h6;

  // frame shape: start, eight data, optional parity, one or two stops
  localparam logic [3:0]  FRAME_BASE    = 4'ha;
  localparam logic [3:0]  STOP_BASE_IDX = 4'h9;
  localparam int unsigned FRAME_MAX     = 12;

  // values after reset
  localparam logic        TX_PIN_RESET  = 1'b1;
  localparam logic        TBE_RESET     = 1'b1;
  localparam logic [7:0]  RX_BUF_RESET  = 8'h00;

  // one-hot state codes
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ast_tx_state_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RUN = 2'b10} ast_rx_state_e;

endpackage : ast_pkg

// >>> pkg/ast_rate_if.sv
// rate selection and oversample tick between core and rate generator
`timescale 1ns/1ps
`default_nettype none
interface ast_rate_if;
  logic [2:0] rateSelect;   // rate code
  logic       timerSrcEn;   // rate timer source clock enable
  logic [7:0] timerCompare; // rate timer compare value
  logic       tick;         // one-cycle oversample tick

  modport gen  (input rateSelect, input timerSrcEn, input timerCompare, output tick);
  modport core (output rateSelect, output timerSrcEn, output timerCompare, input tick);
endinterface : ast_rate_if
`default_nettype wire

// >>> src/ast_rate_gen.sv
// oversample tick generator: fixed divider ladder or rate timer divide
`timescale 1ns/1ps
`default_nettype none
module ast_rate_gen
  import ast_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  ast_rate_if.gen   rif
);

  logic [DIV_W-1:0] divCnt_q, divCnt_d;  // fixed divider count
  logic [7:0]       tmrCnt_q, tmrCnt_d;  // rate timer count
  logic             tick_q,   tick_d;    // registered tick
  logic [DIV_W-1:0] divLast;             // last count of the fixed divider

  // limit doubles per code; the >= compare recovers from a code change
  assign divLast = DIV_W'((BASE_TICK_DIV << rif.rateSelect) - 1);
  assign rif.tick = tick_q;

  // next count and tick
  always_comb begin
    divCnt_d = divCnt_q;
    tmrCnt_d = tmrCnt_q;
    tick_d   = 1'b0;
    if (rif.rateSelect == RATE_TIMER) begin // R2
      divCnt_d = '0;
      if (rif.timerSrcEn) begin
        // compare value zero wraps as 256 source clocks
        if (tmrCnt_q + 8'h01 == rif.timerCompare) begin
          tmrCnt_d = 8'h00;
          tick_d   = 1'b1;
        end else begin
          tmrCnt_d = tmrCnt_q + 8'h01;
        end
      end
    end else if (rif.rateSelect <= LAST_FIXED) begin // R1
      tmrCnt_d = 8'h00;
      if (divCnt_q >= divLast) begin
        divCnt_d = '0;
        tick_d   = 1'b1;
      end else begin
        divCnt_d = divCnt_q + DIV_W'(1);
      end
    end else begin
      // reserved code: no tick at all
      divCnt_d = '0;
      tmrCnt_d = 8'h00;
    end
  end

  // register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= '0;
      tmrCnt_q <= 8'h00;
      tick_q   <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      tmrCnt_q <= tmrCnt_d;
      tick_q   <= tick_d;
    end
  end

  // fixed rates never tick on two cycles in a row
  AST_TICK_SPACING: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
    (tick_q && rif.rateSelect <= LAST_FIXED && $stable(rif.rateSelect)) |=> !tick_q)
    else $error("fixed rate tick repeated on adjacent cycles");

endmodule : ast_rate_gen
`default_nettype wire

// >>> src/ast_uart.sv
// asynchronous serial transceiver core: one-deep buffers, framing, voting receiver
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - codes 000-101 give halving fixed rates
// R2 - code 110 ticks from rate timer compare
// R3 - idle receiver watches line for low level
// R4 - majority of oversample ticks 7, 8, 9
// R5 - one or two stop bits sent
// R6 - parity enable and even/odd select
// R7 - armed write clears empty, starts frame
// R8 - frame start sets empty, raises tx interrupt
// R9 - tx pin high when disabled or unwritten
// R10 - write without status read is ignored
// R11 - frame end stores data, full flag, interrupt
// R12 - full buffer: discard data, flag overrun
// R13 - receive disable waits for frame end
// R14 - software re-receives after framing error
// R15 - parity mismatch sets parity error flag
// R16 - zero stop bit sets framing error
// R17 - status then buffer read clears flags
// R18 - tx end set when idle and empty; code sets it only at frame end, and reset leaves it clear
// R19 - start, eight data, parity, stop framing
// R20 - lsb first, sixteen ticks per bit
// R21 - reset clears enables, flags; empty set
module ast_uart
  import ast_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       transmitEnable,
  input  wire logic       receiveEnable,
  input  wire logic [2:0] rateSelect,
  input  wire logic       stopLengthSelect,
  input  wire logic       parityEnable,
  input  wire logic       parityEven,
  input  wire logic       rateTimerSrcEn,
  input  wire logic [7:0] rateTimerCompare,
  input  wire logic       statusRead,
  input  wire logic       txHoldingBufferWrite,
  input  wire logic [7:0] txWriteData,
  input  wire logic       rxHoldingBufferRead,
  input  wire logic       rxPin,
  output logic            txPin,
  output logic [7:0]      rxHoldingBuffer,
  output logic            txBufferEmptyFlag,
  output logic            rxBufferFullFlag,
  output logic            parityErrorFlag,
  output logic            framingErrorFlag,
  output logic            overrunErrorFlag,
  output logic            txEndFlag,
  output logic            txInterrupt,
  output logic            rxInterrupt
);

  ast_rate_if rif ();  // link to the rate generator

  assign rif.rateSelect   = rateSelect;
  assign rif.timerSrcEn   = rateTimerSrcEn;
  assign rif.timerCompare = rateTimerCompare;

  ast_rate_gen u_rate (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .rif      (rif)
  );

  // ---- line synchroniser and access arming ----
  logic rxMeta_q, rxSync_q;        // two-stage receive pin sync
  logic txArm_q,  txArm_d;         // status read seen before tx write
  logic rxArm_q,  rxArm_d;         // status read seen before rx read
  logic txWrite;                   // accepted tx buffer write
  logic rxClear;                   // accepted rx buffer read

  assign txWrite = txHoldingBufferWrite && txArm_q && transmitEnable; // R10
  assign rxClear = rxHoldingBufferRead && rxArm_q;

  // a status read in the same cycle as the access re-arms (set wins)
  always_comb begin
    txArm_d = statusRead ? 1'b1 : (txHoldingBufferWrite ? 1'b0 : txArm_q); // R10
    rxArm_d = statusRead ? 1'b1 : (rxHoldingBufferRead ? 1'b0 : rxArm_q);  // R17
  end

  // sync and arm registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      txArm_q  <= 1'b0;
      rxArm_q  <= 1'b0;
    end else begin
      rxMeta_q <= rxPin;
      rxSync_q <= rxMeta_q;
      txArm_q  <= txArm_d;
      rxArm_q  <= rxArm_d;
    end
  end

  // ---- transmitter ----
  ast_tx_state_e          txState_q, txState_d;
  logic [3:0]             txTick_q,  txTick_d;    // oversample tick within bit
  logic [3:0]             txBits_q,  txBits_d;    // bits left in frame
  logic [FRAME_MAX-1:0]   txShift_q, txShift_d;   // frame shifter, lsb on the pin
  logic [7:0]             txHold_q,  txHold_d;    // holding buffer
  logic                   txEmpty_q, txEmpty_d;
  logic                   txEnd_q,   txEnd_d;
  logic                   txIrq_d,   txPin_d;
  logic                   txStart;                // frame leaves the buffer
  logic                   txParity;

  // even: bit makes the ones count even; odd: makes it odd
  assign txParity = parityEven ? ^txHold_q : ~^txHold_q; // R6
  // a write on the load cycle would be lost, so the load waits one cycle
  assign txStart  = transmitEnable && !txEmpty_q && !txWrite && (txState_q == TX_IDLE);

  // next transmit state
  always_comb begin
    txState_d = txState_q;
    txTick_d  = txTick_q;
    txBits_d  = txBits_q;
    txShift_d = txShift_q;
    txHold_d  = txHold_q;
    txEmpty_d = txEmpty_q;
    txEnd_d   = txEnd_q;
    txIrq_d   = 1'b0;
    if (txWrite) begin // R7
      txHold_d  = txWriteData;
      txEmpty_d = 1'b0;
    end
    unique case (txState_q)
      TX_IDLE: begin
        if (txStart) begin // R7
          // stops are the filler ones above the last bit, so two stops cost nothing
          txShift_d = parityEnable ? {2'b11, txParity, txHold_q, 1'b0}
                                   : {3'b111, txHold_q, 1'b0}; // R19
          txBits_d  = FRAME_BASE + {3'b000, parityEnable} + {3'b000, stopLengthSelect}; // R5
          txTick_d  = 4'h0;
          txEmpty_d = 1'b1; // R8
          txIrq_d   = 1'b1; // R8
          txEnd_d   = 1'b0; // R18
          txState_d = TX_SEND;
        end
      end
      TX_SEND: begin
        if (rif.tick) begin
          if (txTick_q == LAST_TICK) begin // R20
            txTick_d  = 4'h0;
            txShift_d = {1'b1, txShift_q[FRAME_MAX-1:1]};
            txBits_d  = txBits_q - 4'h1;
            if (txBits_q == 4'h1) begin
              txState_d = TX_IDLE;
              if (txEmpty_q) begin
                txEnd_d = 1'b1; // R18
              end
            end
          end else begin
            txTick_d = txTick_q + 4'h1;
          end
        end
      end
    endcase
    // disabling drops any frame in flight
    if (!transmitEnable) begin // R9
      txState_d = TX_IDLE;
    end
    txPin_d = (txState_d == TX_SEND) ? txShift_d[0] : 1'b1; // R9
  end

  // transmit registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin // R21
      txState_q   <= TX_IDLE;
      txTick_q    <= 4'h0;
      txBits_q    <= 4'h0;
      txShift_q   <= '1;
      txHold_q    <= 8'h00;
      txEmpty_q   <= TBE_RESET;
      txEnd_q     <= 1'b0;
      txPin       <= TX_PIN_RESET;
      txInterrupt <= 1'b0;
    end else begin
      txState_q   <= txState_d;
      txTick_q    <= txTick_d;
      txBits_q    <= txBits_d;
      txShift_q   <= txShift_d;
      txHold_q    <= txHold_d;
      txEmpty_q   <= txEmpty_d;
      txEnd_q     <= txEnd_d;
      txPin       <= txPin_d;
      txInterrupt <= txIrq_d;
    end
  end

  assign txBufferEmptyFlag = txEmpty_q;
  assign txEndFlag         = txEnd_q;

  // ---- receiver ----
  ast_rx_state_e rxState_q, rxState_d;
  logic [3:0]    rxTick_q,  rxTick_d;   // oversample tick within bit
  logic [3:0]    rxIdx_q,   rxIdx_d;    // bit index, 0 is the start bit
  logic [1:0]    rxVote_q,  rxVote_d;   // samples at ticks 7 and 8
  logic [7:0]    rxShift_q, rxShift_d;  // data assembly
  logic          rxPerr_q,  rxPerr_d;   // frame parity mismatch
  logic          rxFerr_q,  rxFerr_d;   // frame stop bit zero
  logic          runEn_q,   runEn_d;    // receive enable as honoured
  logic          feHold_q,  feHold_d;   // framing error froze the enable
  logic [7:0]    rxBuf_d;
  logic          rxFull_d, perrFlag_d, ferrFlag_d, oerrFlag_d, rxIrq_d;
  logic          voted, rxDone, frmPerr, frmFerr;
  logic [3:0]    lastIdx;

  assign voted   = (rxVote_q[0] & rxVote_q[1]) | (rxVote_q[0] & rxSync_q)
                 | (rxVote_q[1] & rxSync_q); // R4
  assign lastIdx = STOP_BASE_IDX + {3'b000, parityEnable} + {3'b000, stopLengthSelect};

  // next receive state
  always_comb begin
    rxState_d  = rxState_q;
    rxTick_d   = rxTick_q;
    rxIdx_d    = rxIdx_q;
    rxVote_d   = rxVote_q;
    rxShift_d  = rxShift_q;
    rxPerr_d   = rxPerr_q;
    rxFerr_d   = rxFerr_q;
    runEn_d    = runEn_q;
    feHold_d   = feHold_q;
    rxBuf_d    = rxHoldingBuffer;
    rxFull_d   = rxBufferFullFlag;
    perrFlag_d = parityErrorFlag;
    ferrFlag_d = framingErrorFlag;
    oerrFlag_d = overrunErrorFlag;
    rxIrq_d    = 1'b0;
    rxDone     = 1'b0;
    frmPerr    = rxPerr_q;
    frmFerr    = rxFerr_q;
    // a fresh read after a framing error releases the frozen enable
    if (rxClear) begin // R14
      feHold_d = 1'b0;
    end
    // read clears; a frame landing in the same cycle sets again below
    if (rxClear) begin // R17
      rxFull_d   = 1'b0;
      perrFlag_d = 1'b0;
      ferrFlag_d = 1'b0;
      oerrFlag_d = 1'b0;
    end
    unique case (rxState_q)
      RX_IDLE: begin
        if (!feHold_q) begin
          runEn_d = receiveEnable; // R13
        end
        if (runEn_q && rif.tick && !rxSync_q) begin // R3
          rxState_d = RX_RUN;
          rxTick_d  = 4'h1;  // the detecting tick was tick 0, so votes land on 7, 8, 9
          rxIdx_d   = 4'h0;
          rxPerr_d  = 1'b0;
          rxFerr_d  = 1'b0;
        end
      end
      RX_RUN: begin
        if (rif.tick) begin
          rxTick_d = rxTick_q + 4'h1; // R20
          if (rxTick_q == SAMPLE_FIRST) begin // R4
            rxVote_d[0] = rxSync_q;
          end
          if (rxTick_q == SAMPLE_SECOND) begin // R4
            rxVote_d[1] = rxSync_q;
          end
          if (rxTick_q == LAST_TICK) begin
            rxIdx_d = rxIdx_q + 4'h1;
          end
          if (rxTick_q == SAMPLE_THIRD) begin
            if (rxIdx_q == 4'h0) begin
              // glitch: start bit did not hold low
              if (voted) begin
                rxState_d = RX_IDLE;
              end
            end else if (rxIdx_q < STOP_BASE_IDX) begin
              rxShift_d = {voted, rxShift_q[7:1]}; // R20
            end else if (parityEnable && rxIdx_q == STOP_BASE_IDX) begin
              rxPerr_d = voted != (parityEven ? ^rxShift_q : ~^rxShift_q); // R15
            end else begin
              frmFerr  = rxFerr_q | !voted; // R16
              rxFerr_d = frmFerr;
              if (rxIdx_q == lastIdx) begin
                rxDone    = 1'b1;
                rxState_d = RX_IDLE;
              end
            end
          end
        end
      end
    endcase
    if (rxDone) begin
      if (frmFerr) begin
        feHold_d = 1'b1; // R13
      end
      if (rxBufferFullFlag && !rxClear) begin
        oerrFlag_d = 1'b1; // R12
      end else begin
        rxBuf_d    = rxShift_q; // R11
        rxFull_d   = 1'b1;
        rxIrq_d    = 1'b1;
        perrFlag_d = perrFlag_d | frmPerr; // R15
        ferrFlag_d = ferrFlag_d | frmFerr; // R16
      end
    end
  end

  // receive registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin // R21
      rxState_q        <= RX_IDLE;
      rxTick_q         <= 4'h0;
      rxIdx_q          <= 4'h0;
      rxVote_q         <= 2'b11;
      rxShift_q        <= 8'h00;
      rxPerr_q         <= 1'b0;
      rxFerr_q         <= 1'b0;
      runEn_q          <= 1'b0;
      feHold_q         <= 1'b0;
      rxHoldingBuffer  <= RX_BUF_RESET;
      rxBufferFullFlag <= 1'b0;
      parityErrorFlag  <= 1'b0;
      framingErrorFlag <= 1'b0;
      overrunErrorFlag <= 1'b0;
      rxInterrupt      <= 1'b0;
    end else begin
      rxState_q        <= rxState_d;
      rxTick_q         <= rxTick_d;
      rxIdx_q          <= rxIdx_d;
      rxVote_q         <= rxVote_d;
      rxShift_q        <= rxShift_d;
      rxPerr_q         <= rxPerr_d;
      rxFerr_q         <= rxFerr_d;
      runEn_q          <= runEn_d;
      feHold_q         <= feHold_d;
      rxHoldingBuffer  <= rxBuf_d;
      rxBufferFullFlag <= rxFull_d;
      parityErrorFlag  <= perrFlag_d;
      framingErrorFlag <= ferrFlag_d;
      overrunErrorFlag <= oerrFlag_d;
      rxInterrupt      <= rxIrq_d;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_TX_DISABLED_HIGH: assert property (!transmitEnable |=> txPin) // R9
    else $error("tx pin low while transmitter disabled");
  AST_TX_START_BIT: assert property (txStart |=> !txPin ##1 !txPin) // R19
    else $error("frame did not open with a low start bit");
  AST_TX_EMPTY_IRQ: assert property (txStart |=> txBufferEmptyFlag && txInterrupt) // R8
    else $error("frame start did not set empty and raise tx interrupt");
  AST_TX_UNARMED: assert property
    (txHoldingBufferWrite && !txArm_q && txBufferEmptyFlag |=> txBufferEmptyFlag) // R10
    else $error("unarmed write cleared the empty flag");
  AST_TX_ARMED: assert property
    (txHoldingBufferWrite && txArm_q && transmitEnable && txBufferEmptyFlag
     |=> !txBufferEmptyFlag ##1 (txState_q == TX_SEND)) // R7
    else $error("armed write did not start a frame");
  AST_TX_END_CLEAR: assert property (txStart |=> !txEndFlag) // R18
    else $error("tx end flag stayed set at frame start");
  AST_RX_STORE: assert property
    (rxDone && !rxBufferFullFlag |=> rxBufferFullFlag && rxInterrupt
     && rxHoldingBuffer == $past(rxShift_q)) // R11
    else $error("completed frame not stored");
  AST_RX_OVERRUN: assert property
    (rxDone && rxBufferFullFlag && !rxClear |=> overrunErrorFlag && $stable(rxHoldingBuffer)
     && !rxInterrupt) // R12
    else $error("overrun not flagged or buffer disturbed");
  AST_RX_CLEAR: assert property
    (rxClear && !rxDone |=> !rxBufferFullFlag && !parityErrorFlag && !framingErrorFlag
     && !overrunErrorFlag) // R17
    else $error("status-then-read did not clear receive flags");
  AST_RX_DISABLE_WAIT: assert property
    ((rxState_q == RX_RUN) && !rxDone |=> runEn_q == $past(runEn_q)) // R13
    else $error("receive enable changed mid frame");

  COV_TX_FRAME:   cover property (txStart ##1 (txState_q == TX_SEND)[*8]);
  COV_RX_STORE:   cover property (rxDone && !rxBufferFullFlag);
  COV_RX_OVERRUN: cover property (rxDone && rxBufferFullFlag);
  COV_RX_FRAMING_ERROR_FLAG:    cover property (rxDone && frmFerr);

endmodule : ast_uart
`default_nettype wire

// >>> tb/ast_remote.sv
// remote serial device: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module ast_remote #(
  parameter int BIT_CYC = 208  // core cycles per bit at rate code 000
) (
  input  wire logic core_clk,
  input  wire logic txLine,
  output logic      rxLine
);
  initial rxLine = 1'b1;  // line idles high between frames

  // frame image, start bit in bit 0, unused tail high
  function automatic logic [11:0] mk_frame(input logic [7:0] d, input logic par,
                                           input logic even, input logic two);
    logic [11:0] f;
    f = 12'hfff;  // stops stay high
    f[0] = 1'b0;  // start bit low
    f[8:1] = d;  // lsb first
    if (par) f[9] = even ? ^d : ~^d;
    return f;
  endfunction : mk_frame

  // send n bits; one bit may carry a short inverted glitch
  task automatic send(input logic [11:0] f, input int n, input int glitchBit);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk) rxLine = f[i];
      if (i == glitchBit) begin
        repeat (BIT_CYC / 2 - 5) @(negedge core_clk);
        rxLine = ~f[i];  // too short to win two of three votes
        repeat (10) @(negedge core_clk);
        rxLine = f[i];
        repeat (BIT_CYC / 2 - 6) @(negedge core_clk);
      end else begin
        repeat (BIT_CYC - 1) @(negedge core_clk);
      end
    end
    @(negedge core_clk) rxLine = 1'b1;
  endtask : send

  // wait for a start edge, then sample each bit at its middle
  task automatic get_frame(input int n, output logic [11:0] f);
    int w;
    f = 'x;
    w = 0;
    while (txLine !== 1'b0 && w < 4 * BIT_CYC) begin
      @(negedge core_clk);
      w++;
    end
    if (txLine === 1'b0) begin
      f = 12'hfff;
      repeat (BIT_CYC / 2) @(negedge core_clk);
      for (int i = 0; i < n; i++) begin
        f[i] = txLine;
        repeat (BIT_CYC) @(negedge core_clk);
      end
    end
  endtask : get_frame
endmodule : ast_remote
`default_nettype wire

// >>> tb/ast_uart_tb_top.sv
// self-checking bench for the serial transceiver core
`timescale 1ns/1ps
`default_nettype none
module ast_uart_tb_top;
  import ast_pkg::*;
  localparam int BIT = 208;  // cycles per bit at rate code 000
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic txEn = 1'b0;
  logic rxEn = 1'b0;
  logic [2:0] rate = 3'h0;
  logic twoStop = 1'b0;
  logic parEn = 1'b0;
  logic parEven = 1'b0;
  logic srcEn = 1'b0;
  logic [7:0] cmp = 8'h01;
  logic stRd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic rd = 1'b0;
  wire logic rxLine;
  wire logic txLine;
  logic [7:0] rxBuf;
  logic empty, full, parity_error_flag, framing_error_flag, overrun_error_flag, endFlag, txIrq, rxIrq;
  logic [11:0] f, got;
  int fails = 0, compares = 0, cyc = 0, rxIrqs = 0;

  always #10 core_clk = ~core_clk;  // 50 MHz

  // rate timer source pulses every other cycle, irq count, hang guard
  always @(negedge core_clk) begin
    srcEn <= ~srcEn;
    cyc <= cyc + 1;
    if (rxIrq === 1'b1) rxIrqs++;
    if (cyc == 90000) begin
      fails++;
      test_done();
    end
  end

  ast_uart i_dut (.core_clk(core_clk), .rst_b(rst_b), .transmitEnable(txEn),
    .receiveEnable(rxEn), .rateSelect(rate), .stopLengthSelect(twoStop),
    .parityEnable(parEn), .parityEven(parEven), .rateTimerSrcEn(srcEn),
    .rateTimerCompare(cmp), .statusRead(stRd), .txHoldingBufferWrite(wr),
    .txWriteData(wrData), .rxHoldingBufferRead(rd), .rxPin(rxLine), .txPin(txLine),
    .rxHoldingBuffer(rxBuf), .txBufferEmptyFlag(empty), .rxBufferFullFlag(full),
    .parityErrorFlag(parity_error_flag), .framingErrorFlag(framing_error_flag), .overrunErrorFlag(overrun_error_flag),
    .txEndFlag(endFlag), .txInterrupt(txIrq), .rxInterrupt(rxIrq));
  ast_remote #(.BIT_CYC(BIT)) i_remote (.core_clk(core_clk), .txLine(txLine),
    .rxLine(rxLine));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (exp !== seen) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // status read pulse arms the next access
  task automatic arm();
    @(negedge core_clk) stRd = 1'b1;
    @(negedge core_clk) stRd = 1'b0;
  endtask : arm

  task automatic write(input logic [7:0] d);
    @(negedge core_clk) begin
      wr = 1'b1;
      wrData = d;
    end
    @(negedge core_clk) wr = 1'b0;
  endtask : write

  // armed read, then one more cycle for the flags to clear
  task automatic read();
    arm();
    @(negedge core_clk) rd = 1'b1;
    @(negedge core_clk) rd = 1'b0;
    @(negedge core_clk);
  endtask : read

  // one transmitted frame, decoded by the remote side
  task automatic tx_frame(input logic [7:0] d);
    f = i_remote.mk_frame(d, parEn, parEven, twoStop);
    arm();
    fork
      i_remote.get_frame(10 + parEn + twoStop, got);
      begin
        write(d);
        chk("empty cleared", 16'h0, 16'(empty));
        @(negedge core_clk);
        chk("empty at start", 16'h1, 16'(empty));
        chk("tx interrupt", 16'h1, 16'(txIrq));
        chk("tx end cleared", 16'h0, 16'(endFlag));
      end
    join
    chk("tx frame", 16'(f), 16'(got));
    chk("tx end set", 16'h1, 16'(endFlag));
  endtask : tx_frame

  // flaw 1 flips parity, 2 zeroes the last stop bit
  task automatic rx_frame(input logic [7:0] d, input int flaw, input int glitch);
    int n;
    n = 10 + parEn + twoStop;
    f = i_remote.mk_frame(d, parEn, parEven, twoStop);
    if (flaw == 1) f[9] = ~f[9];
    if (flaw == 2) f[n-1] = 1'b0;
    i_remote.send(f, n, glitch);
  endtask : rx_frame

  initial begin
    int low, w, len, irq0;
    logic [7:0] d, d2;
    void'($urandom(32'he994));
    repeat (5) @(negedge core_clk);
    chk("reset state", 16'h180, 16'({txLine, empty, full, parity_error_flag, framing_error_flag, overrun_error_flag, endFlag, txIrq,
        rxIrq}));
    chk("reset buffer", 16'(RX_BUF_RESET), 16'(rxBuf));
    rst_b = 1'b1;
    // refused writes: disabled, then unarmed
    arm();
    write(8'h55);
    txEn = 1'b1;
    write(8'h55);
    low = 0;
    repeat (600) @(negedge core_clk) if (txLine !== 1'b1 || empty !== 1'b1) low++;
    chk("tx held idle", 16'h0, 16'(low));
    $display("test refused writes done");
    for (int c = 0; c < 4; c++) begin
      {parEn, twoStop} = 2'(c);
      parEven = c[0];
      tx_frame(c == 0 ? 8'h00 : c == 3 ? 8'hff : 8'($urandom));
    end
    $display("test transmit done");
    rxEn = 1'b1;
    for (int c = 0; c < 4; c++) begin
      {parEn, twoStop} = 2'(c);
      parEven = c[0];
      d = 8'($urandom);
      irq0 = rxIrqs;
      rx_frame(d, 0, c + 1);
      chk("rx data", 16'(d), 16'(rxBuf));
      chk("rx flags", 16'h8, 16'({full, parity_error_flag, framing_error_flag, overrun_error_flag}));
      chk("rx irq", 16'(irq0 + 1), 16'(rxIrqs));
      read();
      chk("flags cleared", 16'h0, 16'({full, parity_error_flag, framing_error_flag, overrun_error_flag}));
    end
    parEn = 1'b1;
    twoStop = 1'b0;
    rx_frame(8'($urandom), 1, -1);
    chk("parity error", 16'hc, 16'({full, parity_error_flag, framing_error_flag, overrun_error_flag}));
    read();
    d = 8'($urandom);
    d2 = ~d;
    rx_frame(d, 0, -1);
    irq0 = rxIrqs;
    rx_frame(d2, 0, -1);
    chk("overrun flags", 16'h9, 16'({full, parity_error_flag, framing_error_flag, overrun_error_flag}));
    chk("overrun keeps", 16'(d), 16'(rxBuf));
    chk("overrun no irq", 16'(irq0), 16'(rxIrqs));
    read();
    chk("flags cleared", 16'h0, 16'({full, parity_error_flag, framing_error_flag, overrun_error_flag}));
    twoStop = 1'b1;
    rx_frame(8'($urandom), 2, -1);
    chk("framing error", 16'ha, 16'({full, parity_error_flag, framing_error_flag, overrun_error_flag}));
    rxEn = 1'b0;
    read();
    repeat (BIT) @(negedge core_clk);  // false start on the zero stop bit must die out first
    irq0 = rxIrqs;
    rx_frame(8'($urandom), 0, -1);
    chk("disabled rx", 16'(irq0), 16'(rxIrqs + 16'(full)));
    rxEn = 1'b1;
    repeat (5) @(negedge core_clk);
    d = 8'($urandom);
    fork
      rx_frame(d, 0, -1);
      begin
        repeat (3 * BIT) @(negedge core_clk);
        rxEn = 1'b0;
      end
    join
    chk("late disable", 16'({1'b1, d}), 16'({full, rxBuf}));
    read();
    rxEn = 1'b1;
    irq0 = rxIrqs;
    i_remote.send(12'hfff, 1, 0);
    repeat (12 * BIT) @(negedge core_clk);
    chk("false start", 16'(irq0), 16'(rxIrqs + 16'(full)));
    $display("test receive done");
    // data bit one length for rate codes 000 to 110
    for (int c = 0; c < 7; c++) begin
      rate = 3'(c);
      cmp = 8'(1 + $urandom % 4);
      arm();
      write(8'hfd);
      // start bit begins off the tick grid, so time data bit one (low after a high bit)
      for (int e = 0; e < 3; e++) begin
        w = 0;
        while (txLine !== e[0] && w < 8000) begin
          @(negedge core_clk);
          w++;
        end
      end
      len = 0;
      while (txLine === 1'b0 && len < 8000) begin
        @(negedge core_clk);
        len++;
      end
      chk("bit period", 16'(c < 6 ? 16 * (BASE_TICK_DIV << c) : 32 * cmp), 16'(len));
      txEn = 1'b0;
      @(negedge core_clk);
      txEn = 1'b1;
    end
    // reserved code: no ticks, so the start bit never ends
    rate = 3'h7;
    arm();
    write(8'h00);
    repeat (300) @(negedge core_clk);
    chk("stalled rate", 16'h0, 16'(txLine));
    $display("test rates done");
    test_done();
  end
endmodule : ast_uart_tb_top
`default_nettype wire
